/* cpa_defs.svh */
`ifndef CPA_DEFS_SVH
`define CPA_DEFS_SVH

// converter sample width
`define CPA_SAMPLE_W 16
// channel selection codes
`define CPA_CH_SHUNT 1'h0
`define CPA_CH_BUS 1'h1
// conversion time table in microseconds, one per select code
`define CPA_CT0_US 140
`define CPA_CT1_US 204
`define CPA_CT2_US 332
`define CPA_CT3_US 588
`define CPA_CT4_US 1100
`define CPA_CT5_US 2116
`define CPA_CT6_US 4156
`define CPA_CT7_US 8244
// device clock rate
`define CPA_CLK_MHZ 50
// shunt step in picovolts per range, bus step in microvolts
`define CPA_SHUNT_STEP_R0_PV 2500000
`define CPA_SHUNT_STEP_R1_PV 625000
`define CPA_BUS_STEP_UV 1600
// current result scaling shift after calibration multiply
`define CPA_CUR_SHIFT 11
// power result scaling shift after current times bus
`define CPA_PWR_SHIFT 16
// reset values
`define CPA_RESULT_RST 16'h0000
`define CPA_CAL_RST 16'h0000

`endif

/* cpa_pkg.sv */
package cpa_pkg;
    `include "cpa_defs.svh"

    typedef logic [`CPA_SAMPLE_W-1:0] sample_t;

    // sequencer phases
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SHUNT,
        ST_BUS,
        ST_MATH,
        ST_LOAD
    } seq_state_t;
endpackage

/* cpa_conv_timer.sv */
`timescale 1ns/1ps
`default_nettype none
// counts one conversion period for the selected conversion time code
module cpa_conv_timer #(
    parameter int SCALE = 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // control
    input wire logic start,
    input wire logic [2:0] ct_sel,
    // status
    output logic done
);
    import cpa_pkg::*;

    typedef struct packed {
        logic [19:0] cnt;
        logic busy;
        logic done;
    } tmr_t;

    tmr_t s_r;
    tmr_t s_nxt;
    logic [19:0] period;

    // period in clock cycles; SCALE lets a simulation shorten it
    always_comb begin
        unique case (ct_sel)
            3'h0: period = 20'((`CPA_CT0_US * `CPA_CLK_MHZ) / SCALE);
            3'h1: period = 20'((`CPA_CT1_US * `CPA_CLK_MHZ) / SCALE);
            3'h2: period = 20'((`CPA_CT2_US * `CPA_CLK_MHZ) / SCALE);
            3'h3: period = 20'((`CPA_CT3_US * `CPA_CLK_MHZ) / SCALE);
            3'h4: period = 20'((`CPA_CT4_US * `CPA_CLK_MHZ) / SCALE);
            3'h5: period = 20'((`CPA_CT5_US * `CPA_CLK_MHZ) / SCALE);
            3'h6: period = 20'((`CPA_CT6_US * `CPA_CLK_MHZ) / SCALE);
            3'h7: period = 20'((`CPA_CT7_US * `CPA_CLK_MHZ) / SCALE);
        endcase
    end

    // count down; done pulses one cycle when the period ends
    always_comb begin
        s_nxt = s_r;
        s_nxt.done = 1'b0;
        if (start) begin
            s_nxt.busy = 1'b1;
            s_nxt.cnt = (period > 20'h00001) ? period - 20'h00001 : 20'h00000;
        end else if (s_r.busy) begin
            if (s_r.cnt == 20'h00000) begin
                s_nxt.busy = 1'b0;
                s_nxt.done = 1'b1;
            end else begin
                s_nxt.cnt = s_r.cnt - 20'h00001;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign done = s_r.done;
endmodule
`default_nettype wire

/* cpa_sync2.sv */
`timescale 1ns/1ps
`default_nettype none
// two-stage synchroniser for a vector of pin levels
module cpa_sync2 #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } sync_t;

    sync_t s_r;
    sync_t s_nxt;

    // first stage feeds only the second
    always_comb begin
        s_nxt.s1 = d;
        s_nxt.s2 = s_r.s1;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign q = s_r.s2;
endmodule
`default_nettype wire

/* current_power_accumulator.sv */
// What this block does
// - One converter is shared, alternating shunt and bus selections, each giving a 16-bit value.
// - Shunt is the difference of the two sense inputs, bus is the negative input against ground.
// - Current and power are computed only after both a shunt and a bus result of the cycle exist; shunt-only needs the shunt alone.
// - Power is the previous sample's current times the newest bus result.
// - A zero calibration value gives a zero power result.
// - Per-sample results are intermediate sums, except at an averaging count of 1.
// - Each sample's current, and its power except in the shunt-only setting, is added into accumulators until the count is reached.
// - When all samples are done, both averages load the output registers in one update.
// - Arithmetic takes one ST_MATH cycle after each bus result, before the next shunt conversion starts.
// - A shunt-only setting skips bus conversions entirely.
// - Shunt steps 2.5 uV or 625 nV by range select, bus steps 1.6 mV.
// - Continuous mode repeats shunt then bus conversions without a new trigger.
// - The ready flag is set only after conversions, averaging and products of a cycle finish.
`timescale 1ns/1ps
`default_nettype none
module current_power_accumulator #(
    parameter int TIME_SCALE = 1,
    parameter int AVG_W = 10
) (
    // clock and reset
    input wire logic CLK,
    input wire logic NRST,
    // configuration from the register side, same clock
    input wire logic CONTINUOUS,
    input wire logic TRIGGER,
    input wire logic SHUNT_ONLY,
    input wire logic [2:0] CONVERSION_TIME_SELECT,
    input wire logic [AVG_W-1:0] AVG_COUNT,
    input wire logic [15:0] CALIBRATION,
    input wire logic READY_CLEAR,
    // converter front end
    output logic ADC_SEL,
    output logic ADC_START,
    input wire logic ADC_DONE,
    input wire logic [15:0] ADC_DATA,
    // results
    output logic [15:0] SHUNT_RESULT,
    output logic [15:0] BUS_RESULT,
    output logic [15:0] CURRENT_RESULT,
    output logic [15:0] POWER_RESULT,
    output logic CONVERSION_READY_FLAG
);
    import cpa_pkg::*;

    localparam int ACC_W = 16 + AVG_W;

    typedef struct packed {
        seq_state_t st;
        logic sel;
        logic start;
        logic tmr_go;
        logic tmr_hit;
        logic got_shunt;
        logic got_bus;
        logic [15:0] shunt;
        logic [15:0] bus;
        logic [15:0] cur_last;
        logic math_go;
        logic [AVG_W-1:0] n;
        logic [ACC_W-1:0] acc_cur;
        logic [ACC_W-1:0] acc_pwr;
        logic [15:0] shunt_out;
        logic [15:0] bus_out;
        logic [15:0] cur_out;
        logic [15:0] pwr_out;
        logic ready;
    } core_t;

    core_t s_r;
    core_t s_nxt;
    logic tmr_done;
    logic adc_done_s;
    logic [15:0] adc_data_s;
    logic [31:0] cur_prod;
    logic [31:0] pwr_prod;
    logic [15:0] cur_smp;
    logic [15:0] pwr_smp;
    logic [AVG_W-1:0] avg_n;
    logic last_smp;
    logic [ACC_W-1:0] cur_sum;
    logic [ACC_W-1:0] pwr_sum;

    // converter result and done arrive from the analog side, resync them
    cpa_sync2 #(.W(17)) u_sync (
        .clk(CLK),
        .nrst(NRST),
        .d({ADC_DONE, ADC_DATA}),
        .q({adc_done_s, adc_data_s})
    );

    // paces each conversion at the selected conversion time
    cpa_conv_timer #(.SCALE(TIME_SCALE)) u_timer (
        .clk(CLK),
        .nrst(NRST),
        .start(s_r.tmr_go),
        .ct_sel(CONVERSION_TIME_SELECT),
        .done(tmr_done)
    );

    // a count of zero is treated as one sample
    assign avg_n = (AVG_COUNT == '0) ? AVG_W'(1) : AVG_COUNT;
    assign last_smp = (s_r.n + AVG_W'(1)) >= avg_n;

    // per-sample arithmetic, purely combinational from latched samples
    assign cur_prod = s_r.shunt * CALIBRATION;
    assign cur_smp = cur_prod[`CPA_CUR_SHIFT +: 16];
    assign pwr_prod = s_r.cur_last * s_r.bus;
    assign pwr_smp = (CALIBRATION == `CPA_CAL_RST) ? 16'h0000 : pwr_prod[`CPA_PWR_SHIFT +: 16];
    assign cur_sum = s_r.acc_cur + ACC_W'(cur_smp);
    assign pwr_sum = s_r.acc_pwr + ACC_W'(pwr_smp);

    // sequencer: shunt then bus, arithmetic in one ST_MATH cycle before the next conversion starts
    always_comb begin
        s_nxt = s_r;
        s_nxt.start = 1'b0;
        s_nxt.tmr_go = 1'b0;
        s_nxt.math_go = 1'b0;
        // clear wins only when nothing sets the flag this cycle
        if (READY_CLEAR) begin
            s_nxt.ready = 1'b0;
        end
        // timer end is a one-cycle pulse; hold it so a slow converter is not lost
        if (tmr_done) begin
            s_nxt.tmr_hit = 1'b1;
        end
        unique case (s_r.st)
            ST_IDLE: begin
                if (CONTINUOUS || TRIGGER) begin
                    s_nxt.n = '0;
                    s_nxt.acc_cur = '0;
                    s_nxt.acc_pwr = '0;
                    s_nxt.st = ST_SHUNT;
                    s_nxt.sel = `CPA_CH_SHUNT;
                    s_nxt.start = 1'b1;
                    s_nxt.tmr_go = 1'b1;
                end
            end
            ST_SHUNT: begin
                if (adc_done_s && (tmr_done || s_r.tmr_hit)) begin
                    s_nxt.tmr_hit = 1'b0;
                    s_nxt.shunt = adc_data_s;
                    s_nxt.got_shunt = 1'b1;
                    if (SHUNT_ONLY) begin
                        // bus phase skipped; math runs on the shunt alone
                        s_nxt.st = ST_MATH;
                    end else begin
                        s_nxt.st = ST_BUS;
                        s_nxt.sel = `CPA_CH_BUS;
                        s_nxt.start = 1'b1;
                        s_nxt.tmr_go = 1'b1;
                    end
                end
            end
            ST_BUS: begin
                if (adc_done_s && (tmr_done || s_r.tmr_hit)) begin
                    s_nxt.tmr_hit = 1'b0;
                    s_nxt.bus = adc_data_s;
                    s_nxt.got_bus = 1'b1;
                    s_nxt.st = ST_MATH;
                end
            end
            ST_MATH: begin
                // both samples present, or the shunt alone in the shunt-only setting, before products are used
                if (s_r.got_shunt && (s_r.got_bus || SHUNT_ONLY)) begin
                    s_nxt.acc_cur = cur_sum;
                    s_nxt.acc_pwr = SHUNT_ONLY ? s_r.acc_pwr : pwr_sum;
                    s_nxt.cur_last = cur_smp;
                    s_nxt.got_shunt = 1'b0;
                    s_nxt.got_bus = 1'b0;
                    s_nxt.n = s_r.n + AVG_W'(1);
                    if (last_smp) begin
                        s_nxt.st = ST_LOAD;
                    end else begin
                        // next shunt start is registered in the same cycle as the sums, after them
                        s_nxt.st = ST_SHUNT;
                        s_nxt.sel = `CPA_CH_SHUNT;
                        s_nxt.start = 1'b1;
                        s_nxt.tmr_go = 1'b1;
                    end
                end else begin
                    s_nxt.st = ST_IDLE;
                end
            end
            ST_LOAD: begin
                // divide by the count; a count of 1 passes the sample as final
                s_nxt.cur_out = 16'(s_r.acc_cur / ACC_W'(avg_n));
                s_nxt.pwr_out = 16'(s_r.acc_pwr / ACC_W'(avg_n));
                s_nxt.shunt_out = s_r.shunt;
                s_nxt.bus_out = s_r.bus;
                s_nxt.ready = 1'b1;
                s_nxt.n = '0;
                s_nxt.acc_cur = '0;
                s_nxt.acc_pwr = '0;
                if (CONTINUOUS) begin
                    s_nxt.st = ST_SHUNT;
                    s_nxt.sel = `CPA_CH_SHUNT;
                    s_nxt.start = 1'b1;
                    s_nxt.tmr_go = 1'b1;
                end else begin
                    s_nxt.st = ST_IDLE;
                end
            end
            default: begin
                s_nxt.st = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // all outputs straight from the state register
    assign ADC_SEL = s_r.sel;
    assign ADC_START = s_r.start;
    assign SHUNT_RESULT = s_r.shunt_out;
    assign BUS_RESULT = s_r.bus_out;
    assign CURRENT_RESULT = s_r.cur_out;
    assign POWER_RESULT = s_r.pwr_out;
    assign CONVERSION_READY_FLAG = s_r.ready;
endmodule
`default_nettype wire

/* cpa_adc_model.sv */
`timescale 1ns/1ps
`default_nettype none
// converter stand-in: latches its input at start, answers lat+1 cycles after the start edge
module cpa_adc_model (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // control from the block
    input wire logic start,
    input wire logic sel,
    // sense inputs and answer delay
    input wire logic [15:0] vpos,
    input wire logic [15:0] vneg,
    input wire logic [3:0] lat,
    // answer
    output logic done,
    output logic [15:0] data
);
    logic [15:0] val;
    int cnt;
    // data toggles until valid, so a stale word never passes for a result
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            done <= 1'b0;
            data <= 16'h0000;
            val <= 16'h0000;
            cnt <= 0;
        end else if (start) begin
            val <= sel ? vneg : vpos - vneg;
            cnt <= lat + 1;
            done <= 1'b0;
            data <= ~data;
        end else if (cnt > 1) begin
            cnt <= cnt - 1;
            data <= ~data;
        end else if (cnt == 1) begin
            cnt <= 0;
            done <= 1'b1;
            data <= val;
        end
    end
endmodule
`default_nettype wire

/* current_power_accumulator_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module current_power_accumulator_chk (
    // clock and reset
    input wire logic CLK,
    input wire logic NRST,
    // configuration
    input wire logic CONTINUOUS,
    input wire logic SHUNT_ONLY,
    input wire logic [15:0] CALIBRATION,
    input wire logic READY_CLEAR,
    // converter and results
    input wire logic ADC_SEL,
    input wire logic ADC_START,
    input wire logic [15:0] CURRENT_RESULT,
    input wire logic [15:0] POWER_RESULT,
    input wire logic CONVERSION_READY_FLAG
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!NRST);
    logic last_sel_r;
    // last channel started; reset to bus so the first start must be shunt
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) last_sel_r <= 1'b1;
        else if (ADC_START) last_sel_r <= ADC_SEL;
    end
    a_start_single: assert property (ADC_START |=> !ADC_START [*3])
        else $error("start pulse too long or conversions overlap");
    a_sel_alternate: assert property (ADC_START && !SHUNT_ONLY |-> ADC_SEL != last_sel_r)
        else $error("shunt and bus do not alternate");
    a_shunt_only: assert property (ADC_START && SHUNT_ONLY |-> !ADC_SEL)
        else $error("bus conversion in shunt-only setting");
    a_cont_restart: assert property (CONTINUOUS && ADC_START
        |-> ##[1:1000] (ADC_START || !CONTINUOUS))
        else $error("continuous conversions stalled");
    a_load_ready: assert property ($changed(CURRENT_RESULT) || $changed(POWER_RESULT)
        |-> CONVERSION_READY_FLAG)
        else $error("results changed without ready flag");
    a_ready_late: assert property ($rose(CONVERSION_READY_FLAG)
        |-> !$past(ADC_START) && !$past(ADC_START, 2))
        else $error("ready flag set too soon after a start");
    a_power_zero: assert property (CALIBRATION == 16'h0000 && $stable(CALIBRATION)
        && $changed(POWER_RESULT) |-> POWER_RESULT == 16'h0000)
        else $error("nonzero power with zero calibration");
    a_flag_clear: assert property ($fell(CONVERSION_READY_FLAG) |-> $past(READY_CLEAR))
        else $error("ready flag fell without clear");
    cover property ($rose(CONVERSION_READY_FLAG));
    cover property (ADC_START && ADC_SEL);
    cover property (ADC_START && SHUNT_ONLY);
endmodule
bind current_power_accumulator current_power_accumulator_chk i_chk (.CLK(CLK), .NRST(NRST),
    .CONTINUOUS(CONTINUOUS), .SHUNT_ONLY(SHUNT_ONLY), .CALIBRATION(CALIBRATION),
    .READY_CLEAR(READY_CLEAR), .ADC_SEL(ADC_SEL), .ADC_START(ADC_START),
    .CURRENT_RESULT(CURRENT_RESULT), .POWER_RESULT(POWER_RESULT),
    .CONVERSION_READY_FLAG(CONVERSION_READY_FLAG));
`default_nettype wire

/* current_power_accumulator_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module current_power_accumulator_tb_top;
    logic CLK = 1'b0, NRST = 1'b0, CONTINUOUS = 1'b0, TRIGGER = 1'b0, SHUNT_ONLY = 1'b0;
    logic READY_CLEAR = 1'b0, ADC_SEL, ADC_START, ADC_DONE, CONVERSION_READY_FLAG;
    logic [2:0] CONVERSION_TIME_SELECT = 3'h0;
    logic [9:0] AVG_COUNT = 10'h001;
    logic [15:0] CALIBRATION = 16'h0000, ADC_DATA, vpos = 16'h0000, vneg = 16'h0000;
    logic [15:0] SHUNT_RESULT, BUS_RESULT, CURRENT_RESULT, POWER_RESULT;
    logic [3:0] lat = 4'h0;
    int err_total = 0, cmp_count = 0, seed = 51, cur_last = 0;
    int sq[$], bq[$];
    initial forever #10 CLK = ~CLK;
    // scale 1000 keeps the slowest conversion near 400 cycles
    current_power_accumulator #(.TIME_SCALE(1000)) i_dut (.CLK(CLK), .NRST(NRST),
        .CONTINUOUS(CONTINUOUS), .TRIGGER(TRIGGER), .SHUNT_ONLY(SHUNT_ONLY),
        .CONVERSION_TIME_SELECT(CONVERSION_TIME_SELECT), .AVG_COUNT(AVG_COUNT),
        .CALIBRATION(CALIBRATION), .READY_CLEAR(READY_CLEAR), .ADC_SEL(ADC_SEL),
        .ADC_START(ADC_START), .ADC_DONE(ADC_DONE), .ADC_DATA(ADC_DATA),
        .SHUNT_RESULT(SHUNT_RESULT), .BUS_RESULT(BUS_RESULT),
        .CURRENT_RESULT(CURRENT_RESULT), .POWER_RESULT(POWER_RESULT),
        .CONVERSION_READY_FLAG(CONVERSION_READY_FLAG));
    cpa_adc_model i_adc (.clk(CLK), .nrst(NRST), .start(ADC_START), .sel(ADC_SEL),
        .vpos(vpos), .vneg(vneg), .lat(lat), .done(ADC_DONE), .data(ADC_DATA));
    // inputs wander each cycle but hold while a start latches them
    always @(negedge CLK) begin
        if (ADC_START === 1'b1) begin
            if (ADC_SEL === 1'b1) bq.push_back(vneg);
            else sq.push_back(16'(vpos - vneg));
        end else begin
            vneg = 16'($random(seed));
            vpos = vneg + 16'($random(seed) & 255); // small shunt keeps products in range
            lat = 4'($random(seed));
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one averaging run; ncyc 2 means two back-to-back continuous cycles
    task automatic run(input int avg, input logic [15:0] cal, input logic so, input int ncyc);
        int n, s, b, c, sc, sp, w;
        n = (avg == 0) ? 1 : avg;
        @(negedge CLK);
        AVG_COUNT = 10'(avg);
        CALIBRATION = cal;
        SHUNT_ONLY = so;
        CONVERSION_TIME_SELECT = 3'($random(seed));
        CONTINUOUS = (ncyc > 1);
        TRIGGER = 1'b1;
        @(negedge CLK);
        TRIGGER = 1'b0;
        repeat (ncyc) begin
            w = 0;
            while (CONVERSION_READY_FLAG !== 1'b1 && w < 40000) begin
                @(negedge CLK);
                w++;
            end
            if (w >= 40000) err_total++;
            sc = 0;
            sp = 0;
            repeat (n) begin
                s = sq.pop_front();
                c = (s * int'(cal)) >> 11;
                if (!so) begin
                    b = bq.pop_front();
                    sp += (cal == 0) ? 0 : (cur_last * b) >> 16;
                end
                cur_last = c;
                sc += c;
            end
            chk(CURRENT_RESULT, 16'(sc / n));
            chk(SHUNT_RESULT, 16'(s));
            if (!so) chk(POWER_RESULT, 16'(sp / n));
            if (!so) chk(BUS_RESULT, 16'(b));
            READY_CLEAR = 1'b1;
            @(negedge CLK);
            READY_CLEAR = 1'b0;
            @(negedge CLK);
            chk({15'h0000, CONVERSION_READY_FLAG}, 16'h0000);
            w = 0;
            while (CONTINUOUS && ADC_START !== 1'b1 && w < 2000) begin
                @(negedge CLK);
                w++;
            end
            CONTINUOUS = 1'b0;
        end
    endtask
    task automatic conclude();
        if (err_total == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // bound well above the slowest expected run
    initial begin
        repeat (100000) @(posedge CLK);
        err_total++;
        conclude();
    end
    initial begin
        repeat (12) @(negedge CLK);
        NRST = 1'b1;
        run(1, 16'($random(seed)) & 16'h07FF, 1'b0, 1);
        run(4, 16'($random(seed)) & 16'h07FF, 1'b0, 1);
        run(0, 16'($random(seed)) & 16'h07FF, 1'b0, 1);
        run(3, 16'h0000, 1'b0, 1);
        run(2, 16'($random(seed)) & 16'h07FF, 1'b0, 2);
        run(3, 16'($random(seed)) & 16'h07FF, 1'b1, 1);
        conclude();
    end
endmodule
`default_nettype wire
